// File: design/motor_driver_serial_port.sv
// serial register port of a three-phase motor driver, standard and multidrop
// assumes: reset is applied while chip select is high; mode and id straps
// stay still after reset; the serial clock idles low between frames
`timescale 1ns/10ps
`default_nettype none

module motor_driver_serial_port
  import motor_serial_pkg::*;
#(
  parameter int RESET_WINDOW = RESET_WINDOW_CYCLES
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  input wire logic multidropSerialMode,
  input wire logic idSelectPin0,
  input wire logic idSelectPin1,
  input wire logic sleepNPin,
  input wire logic faultConditionActive,
  input wire logic faultEvent,
  input wire logic [DEV_STATUS_BITS-1:0] deviceStatus,
  output logic faultNPin,
  output logic driverEnable,
  output logic sleepShutdown
);

  // ---------------- system clock side ----------------
  logic [SYNC_WIDTH-1:0] syncIn;
  logic [SYNC_WIDTH-1:0] sync1_q;
  logic [SYNC_WIDTH-1:0] sync2_q;
  logic [SYNC_WIDTH-1:0] sync3_q;
  logic [SYNC_WIDTH-1:0] stable_q;
  logic [SYNC_WIDTH-1:0] prev_q;
  logic strapDone_q;
  logic modeMd_q;
  logic [1:0] idPins_q;
  logic [LOW_CNT_BITS-1:0] lowCnt_q;
  logic devFault_q;
  logic devFault_d;
  logic parFlag_q;
  logic parFlag_d;
  logic frmFlag_q;
  logic frmFlag_d;
  logic [STATUS_BITS-1:0] status_q;
  logic csRise;
  logic sleepRise;
  logic pulseClear;
  logic clearReq;
  logic parityEvt;
  logic frameEvt;

  // serial side state read across the boundary
  logic partial_q;
  logic parityTog_q;
  logic clearTog_q;

  assign syncIn = {chipSelectN, sleepNPin, partial_q, parityTog_q,
    clearTog_q};

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sync1_q <= SYNC_RESET;
      sync2_q <= SYNC_RESET;
      sync3_q <= SYNC_RESET;
      stable_q <= SYNC_RESET;
      prev_q <= SYNC_RESET;
    end
    else
    begin
      sync1_q <= syncIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      stable_q <= (~(sync2_q ^ sync3_q) & sync3_q) |
        ((sync2_q ^ sync3_q) & stable_q);
      prev_q <= stable_q;
    end
  end

  // straps caught once after release, then held for the serial side
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      strapDone_q <= 1'b0;
      modeMd_q <= 1'b0;
      idPins_q <= 2'h0;
    end
    else if (!strapDone_q)
    begin
      strapDone_q <= 1'b1;
      modeMd_q <= multidropSerialMode;
      idPins_q <= {idSelectPin1, idSelectPin0};
    end
  end

  assign csRise = stable_q[IX_CS] & ~prev_q[IX_CS];
  assign sleepRise = stable_q[IX_SLEEP] & ~prev_q[IX_SLEEP];
  assign parityEvt = stable_q[IX_PARITY_TOG] ^ prev_q[IX_PARITY_TOG];
  assign frameEvt = csRise & stable_q[IX_PARTIAL];
  assign pulseClear = sleepRise & ~sleepShutdown;
  assign clearReq = pulseClear |
    (stable_q[IX_CLEAR_TOG] ^ prev_q[IX_CLEAR_TOG]);

  // measure low time of the sleep pin
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      lowCnt_q <= '0;
      sleepShutdown <= 1'b0;
    end
    else if (stable_q[IX_SLEEP])
    begin
      lowCnt_q <= '0;
      sleepShutdown <= 1'b0;
    end
    else
    begin
      if (lowCnt_q < LOW_CNT_BITS'(RESET_WINDOW))
        lowCnt_q <= lowCnt_q + 1'b1;
      else
        sleepShutdown <= 1'b1;
    end
  end

  // set wins over clear; a clear request while the condition is active is dropped
  always_comb
  begin
    devFault_d = devFault_q;
    parFlag_d = parFlag_q;
    frmFlag_d = frmFlag_q;
    // clear only once the cause is gone
    if (clearReq && !faultConditionActive)
    begin
      devFault_d = 1'b0;
      parFlag_d = 1'b0;
      frmFlag_d = 1'b0;
    end
    if (faultEvent)
      devFault_d = 1'b1;
    if (parityEvt)
      parFlag_d = 1'b1;
    if (frameEvt)
      frmFlag_d = 1'b1;
  end

  // clearing touches only the fault latches
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      devFault_q <= 1'b0;
      parFlag_q <= 1'b0;
      frmFlag_q <= 1'b0;
      faultNPin <= 1'b1;
      driverEnable <= 1'b1;
      status_q <= '0;
    end
    else
    begin
      devFault_q <= devFault_d;
      parFlag_q <= parFlag_d;
      frmFlag_q <= frmFlag_d;
      // fault pin low on any latch
      faultNPin <= ~(devFault_d | parFlag_d | frmFlag_d |
        faultConditionActive);
      driverEnable <= ~devFault_d;
      status_q <= {devFault_d | parFlag_d | frmFlag_d, parFlag_d, frmFlag_d,
        deviceStatus};
    end
  end

  // ---------------- serial clock side ----------------
  logic armed_q;
  phase_type phase_q;
  phase_type curPhase;
  logic [POS_BITS-1:0] bitPos_q;
  logic [POS_BITS-1:0] curPos;
  logic [POS_BITS-1:0] posNext;
  logic [POS_BITS-1:0] hdrLen;
  logic [POS_BITS-1:0] statusStart;
  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] shNext;
  logic selSeen_q;
  logic select_q;
  logic accept_q;
  logic isWrite_q;
  logic blocked_q;
  logic [PTR_BITS-1:0] hdrAddr_q;
  logic [PTR_BITS-1:0] rdPtr_q;
  logic [PTR_BITS-1:0] wrPtr_q;
  logic [WORD_BITS-1:0] ctrl_q;
  logic [WORD_BITS-1:0] dataOut_q;
  logic [WORD_BITS-1:0] bank [0:(1<<PTR_BITS)-1];
  logic [STATUS_BITS-1:0] stsS1_q;
  logic [STATUS_BITS-1:0] stsS2_q;
  logic [STATUS_BITS-1:0] stsS3_q;
  logic [STATUS_BITS-1:0] stsLink_q;
  logic active;
  logic inHeader;
  logic blocked;
  logic selDone;
  logic addrDone;
  logic hdrDone;
  logic wordDone;
  logic rwNow;
  logic [MD_ID_BITS-1:0] idNow;
  logic matchNow;
  logic [PTR_BITS-1:0] addrNow;
  logic penable;
  logic hdrPerr;
  logic wrOk;
  logic dataPerr;
  logic doWrite;
  logic unitActive;
  logic outBit;
  logic drive;

  function automatic logic [WORD_BITS-1:0] readReg(
    input logic [PTR_BITS-1:0] ptr);
    logic [WORD_BITS-1:0] v;
    if (ptr == SYSTEM_CONTROL_REG_ADDR)
      v = ctrl_q;
    else if (ptr == SYS_STATUS_ADDR)
      v = {{(WORD_BITS-STATUS_BITS){1'b0}}, stsLink_q};
    else
      v = bank[ptr];
    if (ctrl_q[PARITY_EN_BIT])
      v[WORD_BITS-1] = ^v[WORD_BITS-2:0];
    return v;
  endfunction

  // frame start flag, set while chip select is high
  always_ff @(negedge serialClk or posedge reset or posedge chipSelectN)
  begin
    if (reset)
      armed_q <= 1'b1;
    else if (chipSelectN)
      armed_q <= 1'b1;
    else
      armed_q <= 1'b0;
  end

  always_comb
  begin
    active = ~chipSelectN;
    curPos = armed_q ? '0 : bitPos_q;
    curPhase = armed_q ? PH_HEADER : phase_q;
    blocked = armed_q ? 1'b0 : blocked_q;
    shNext = armed_q ? {{(WORD_BITS-1){1'b0}}, serialDataIn} :
      {shift_q[WORD_BITS-2:0], serialDataIn};
    posNext = curPos + 1'b1;
    inHeader = (curPhase == PH_HEADER);
    hdrLen = modeMd_q ? MD_HEADER_BITS : STD_HEADER_BITS;
    statusStart = hdrLen - POS_BITS'(STATUS_BITS);
    selDone = active && inHeader &&
      (posNext == (modeMd_q ? MD_SEL_DONE : STD_SEL_DONE));
    addrDone = active && inHeader &&
      (posNext == (modeMd_q ? MD_ADDR_DONE : STD_ADDR_DONE));
    hdrDone = active && inHeader && (posNext == hdrLen);
    wordDone = active && !inHeader && (posNext == WORD_DONE);
    rwNow = modeMd_q ? shNext[MD_RW_POS] : shNext[STD_RW_POS];
    idNow = shNext[MD_ID_BITS-1:0];
    matchNow = !modeMd_q || (idNow == {ID_FIXED_UPPER, idPins_q});
    // standard addresses are six bits wide
    addrNow = modeMd_q ? shNext[MD_ADDR_BITS-1:0] :
      {{(PTR_BITS-STD_ADDR_BITS){1'b0}}, shNext[STD_ADDR_BITS-1:0]};
    penable = ctrl_q[PARITY_EN_BIT];
    unitActive = isWrite_q ? accept_q : select_q;
    // even parity over the header block
    hdrPerr = hdrDone && penable && unitActive &&
      (modeMd_q ? ^shNext : ^shNext[STD_HEADER_BITS-1:0]);
    wrOk = wordDone && isWrite_q && accept_q && !blocked;
    // even parity over the data block
    dataPerr = wrOk && penable && ^shNext;
    doWrite = wrOk && !dataPerr;
  end

  // frame position tracking
  always_ff @(negedge serialClk)
  begin
    if (active)
    begin
      shift_q <= shNext;
      if (hdrDone)
      begin
        phase_q <= PH_DATA;
        bitPos_q <= '0;
      end
      else if (wordDone)
      begin
        phase_q <= curPhase;
        bitPos_q <= '0;
      end
      else
      begin
        phase_q <= curPhase;
        bitPos_q <= posNext;
      end
      partial_q <= ~(hdrDone | wordDone);
    end
  end

  // header decode
  always_ff @(negedge serialClk)
  begin
    if (active)
    begin
      selSeen_q <= (armed_q ? 1'b0 : selSeen_q) | selDone;
      if (selDone)
      begin
        isWrite_q <= ~rwNow;
        select_q <= matchNow;
        accept_q <= matchNow |
          (modeMd_q && idNow == GENERAL_CALL_ID && !rwNow);
      end
      if (addrDone)
        hdrAddr_q <= addrNow;
      // block the remaining writes of the transfer
      blocked_q <= blocked | hdrPerr | dataPerr;
    end
  end

  // pointers and control register
  always_ff @(negedge serialClk or posedge reset)
  begin
    if (reset)
    begin
      rdPtr_q <= '0;
      wrPtr_q <= '0;
      ctrl_q <= SYSTEM_CONTROL_REG_RESET;
      clearTog_q <= 1'b0;
      parityTog_q <= 1'b0;
    end
    else
    begin
      // read pointer loads at the address
      if (addrDone && !isWrite_q && select_q)
        rdPtr_q <= addrNow;
      else if (wordDone && unitActive)
        rdPtr_q <= rdPtr_q + 1'b1;
      if (hdrDone && isWrite_q && accept_q && !hdrPerr)
        wrPtr_q <= hdrAddr_q;
      // write pointer steps on stored words
      else if (doWrite)
        wrPtr_q <= wrPtr_q + 1'b1;
      // clear bit is self-clearing so it never reads back set
      if (doWrite && wrPtr_q == SYSTEM_CONTROL_REG_ADDR)
      begin
        ctrl_q <= shNext & ~(WORD_BITS'(1) << CLEAR_FAULT_BIT);
        clearTog_q <= clearTog_q ^ shNext[CLEAR_FAULT_BIT];
      end
      // report error to the system side
      parityTog_q <= parityTog_q ^ (hdrPerr | dataPerr);
    end
  end

  // register contents; no reset, software owns them
  always_ff @(negedge serialClk)
  begin
    if (doWrite && wrPtr_q != SYSTEM_CONTROL_REG_ADDR && wrPtr_q != SYS_STATUS_ADDR)
      bank[wrPtr_q] <= shNext;
  end

  // answer data always from the read pointer
  always_ff @(negedge serialClk)
  begin
    if (hdrDone)
      dataOut_q <= readReg(rdPtr_q);
    else if (wordDone)
      dataOut_q <= readReg(unitActive ? rdPtr_q + 1'b1 : rdPtr_q);
  end

  // status bits; only move while the link clock runs, so in standard mode the first
  // four bits of the byte show the state at the end of the previous frame
  always_ff @(negedge serialClk or posedge reset)
  begin
    if (reset)
    begin
      stsS1_q <= '0;
      stsS2_q <= '0;
      stsS3_q <= '0;
      stsLink_q <= '0;
    end
    else
    begin
      stsS1_q <= status_q;
      stsS2_q <= stsS1_q;
      stsS3_q <= stsS2_q;
      stsLink_q <= (~(stsS2_q ^ stsS3_q) & stsS3_q) |
        ((stsS2_q ^ stsS3_q) & stsLink_q);
    end
  end

  always_comb
  begin
    if (inHeader)
      outBit = (curPos >= statusStart) ?
        stsLink_q[3'(STATUS_BITS - 1) - 3'(curPos - statusStart)] : 1'b0;
    else
      outBit = dataOut_q[4'(WORD_BITS - 1) - 4'(curPos)];
    // addressed device keeps driving after errors
    drive = !modeMd_q ||
      (selSeen_q && !armed_q && select_q &&
      !(inHeader && curPos < statusStart));
  end

  // released while chip select is high
  always_ff @(posedge serialClk or posedge reset or posedge chipSelectN)
  begin
    if (reset)
    begin
      serialDataOut <= 1'b0;
      serialDataOe <= 1'b0;
    end
    else if (chipSelectN)
    begin
      serialDataOut <= 1'b0;
      serialDataOe <= 1'b0;
    end
    else
    begin
      serialDataOut <= outBit;
      serialDataOe <= drive;
    end
  end

endmodule

`default_nettype wire

// File: design/motor_serial_pkg.sv
// constants and types for the motor driver serial register port
// assumes a 50 MHz system clock and a serial link clock of its own
package motor_serial_pkg;

  localparam int WORD_BITS = 16;
  localparam int STATUS_BITS = 8;
  localparam int PTR_BITS = 8;
  localparam int STD_ADDR_BITS = 6;
  localparam int MD_ADDR_BITS = 8;
  localparam int MD_ID_BITS = 4;
  localparam int POS_BITS = 5;
  localparam int DEV_STATUS_BITS = 5;

  // positions counted in bits captured since the frame start, WORD_DONE since the word start
  localparam logic [4:0] STD_HEADER_BITS = 5'd8;
  localparam logic [4:0] MD_HEADER_BITS = 5'd16;
  localparam logic [4:0] STD_SEL_DONE = 5'd1;
  localparam logic [4:0] MD_SEL_DONE = 5'd5;
  localparam logic [4:0] STD_ADDR_DONE = 5'd7;
  localparam logic [4:0] MD_ADDR_DONE = 5'd13;
  localparam logic [4:0] WORD_DONE = 5'd16;
  localparam int STD_RW_POS = 0;
  localparam int MD_RW_POS = 4;

  localparam logic [1:0] ID_FIXED_UPPER = 2'h0;
  localparam logic [3:0] GENERAL_CALL_ID = 4'hf;

  // control and status locations inside the register space
  localparam logic [7:0] SYS_STATUS_ADDR = 8'h3e;
  localparam logic [7:0] SYSTEM_CONTROL_REG_ADDR = 8'h3f;
  localparam logic [15:0] SYSTEM_CONTROL_REG_RESET = 16'h0000;
  localparam int PARITY_EN_BIT = 0;
  localparam int CLEAR_FAULT_BIT = 1;
  localparam int STS_FAULT_BIT = 7;
  localparam int STS_PARITY_BIT = 6;
  localparam int STS_FRAME_BIT = 5;

  // indices of the vector synchronised into the system clock
  localparam int SYNC_WIDTH = 5;
  localparam int IX_CS = 4;
  localparam int IX_SLEEP = 3;
  localparam int IX_PARTIAL = 2;
  localparam int IX_PARITY_TOG = 1;
  localparam int IX_CLEAR_TOG = 0;
  localparam logic [4:0] SYNC_RESET = 5'h18;

  localparam int CLK_MHZ = 50;
  localparam int RESET_WINDOW_NS = 40000;
  localparam int RESET_WINDOW_CYCLES = RESET_WINDOW_NS * CLK_MHZ / 1000;
  localparam int LOW_CNT_BITS = 16;

  typedef enum logic [1:0] {
    PH_HEADER = 2'b01,
    PH_DATA = 2'b10
  } phase_type;

endpackage

// File: verification/motor_port_asserts.sv
// checker for the fault, sleep and output-enable side of the serial port
// assumes the design top ports only, all sampled on mclk
`timescale 1ns/10ps
`default_nettype none

module motor_port_asserts
#(
  parameter int RESET_WINDOW = 20
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic chipSelectN,
  input wire logic serialDataOe,
  input wire logic sleepNPin,
  input wire logic faultConditionActive,
  input wire logic faultEvent,
  input wire logic faultNPin,
  input wire logic driverEnable,
  input wire logic sleepShutdown
);
  int lowCnt;

  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);

  // raw low time of the sleep pin; saturates to stay cheap
  always_ff @(posedge mclk)
  begin
    if (reset || sleepNPin)
      lowCnt <= 0;
    else if (lowCnt < 1000)
      lowCnt <= lowCnt + 1;
  end

  property p_oe_idle;
    chipSelectN |-> !serialDataOe;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data line driven while deselected");

  property p_cond_low;
    faultConditionActive |=> !faultNPin;
  endproperty
  a_cond_low: assert property (p_cond_low)
    else $error("fault pin released while cause persists");

  property p_event;
    faultEvent |-> ##[1:2] !driverEnable;
  endproperty
  a_event: assert property (p_event)
    else $error("fault event did not stop the driver");

  property p_pin_dev;
    !driverEnable |-> !faultNPin;
  endproperty
  a_pin_dev: assert property (p_pin_dev)
    else $error("driver stopped but fault pin high");

  property p_pin_rel;
    $rose(faultNPin) |-> !$past(faultConditionActive);
  endproperty
  a_pin_rel: assert property (p_pin_rel)
    else $error("fault pin rose with cause active");

  property p_en_rel;
    $rose(driverEnable) |-> !$past(faultConditionActive, 2);
  endproperty
  a_en_rel: assert property (p_en_rel)
    else $error("driver restarted with cause active");

  property p_sleep_long;
    $rose(sleepShutdown) |-> lowCnt >= RESET_WINDOW;
  endproperty
  a_sleep_long: assert property (p_sleep_long)
    else $error("shutdown after a short low pulse");

  property p_sleep_quick;
    lowCnt == RESET_WINDOW + 8 |-> sleepShutdown;
  endproperty
  a_sleep_quick: assert property (p_sleep_quick)
    else $error("long low pulse gave no shutdown");

  property p_sleep_wake;
    sleepShutdown && sleepNPin |-> ##[1:6] !sleepShutdown;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("shutdown held after pin high");
endmodule

bind motor_driver_serial_port motor_port_asserts
  #(.RESET_WINDOW(RESET_WINDOW)) u_chk (.mclk, .reset, .chipSelectN,
  .serialDataOe, .sleepNPin, .faultConditionActive, .faultEvent,
  .faultNPin, .driverEnable, .sleepShutdown);

`default_nettype wire

// File: verification/spi_primary_model.sv
// serial primary controller model: frames, link clock, data line
// assumes a 12 ns link clock period and callers that wait between frames
`timescale 1ns/10ps
`default_nettype none

module spi_primary_model
(
  output logic serialClk,
  output logic chipSelectN,
  output logic serialDataIn,
  input wire logic serialDataOut,
  input wire logic serialDataOe
);
  initial
  begin
    serialClk = 1'b0;
    chipSelectN = 1'b1;
    serialDataIn = 1'b0;
  end

  task automatic frame(input int n, input logic [63:0] tx,
      output logic [63:0] rx, output int oeCnt);
    rx = '0;
    oeCnt = 0;
    // clock low at both select edges
    chipSelectN = 1'b0;
    #6;
    // drive on rise, sample on fall, msb first
    for (int i = n - 1; i >= 0; i--)
    begin
      serialClk = 1'b1;
      serialDataIn = tx[i];
      #6;
      serialClk = 1'b0;
      // a released line reads as the opposite of the last bit
      rx[i] = serialDataOe ? serialDataOut : ~serialDataOut;
      if (serialDataOe === 1'b1)
        oeCnt++;
      #6;
    end
    chipSelectN = 1'b1;
    // released line shows no stale bit
    serialDataIn = ~serialDataIn;
    #6;
  endtask
endmodule

`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the motor driver serial port
// assumes spi_primary_model drives the link and a 50 MHz mclk
`timescale 1ns/10ps
`default_nettype none

module tb;
  import motor_serial_pkg::*;
  localparam int RW = 20;
  logic mclk = 1'b0;
  logic reset;
  logic md = 1'b0;
  logic id0 = 1'b0;
  logic id1 = 1'b0;
  logic sleepN = 1'b1;
  logic cond = 1'b0;
  logic evt = 1'b0;
  logic [4:0] devSt = 5'h00;
  logic sck, csN, sdi, sdo, sdoOe, faultN, drvEn, shut, pen;
  logic [15:0] mem [256];
  logic [7:0] rp, wp;
  logic [3:0] own;
  logic [63:0] rx;
  int oe, stsOk, failures, n_checks;

  always #10 mclk = ~mclk;

  motor_driver_serial_port #(.RESET_WINDOW(RW)) i_motor_driver_serial_port (
    .mclk(mclk), .reset(reset), .serialClk(sck), .chipSelectN(csN),
    .serialDataIn(sdi), .serialDataOut(sdo), .serialDataOe(sdoOe),
    .multidropSerialMode(md), .idSelectPin0(id0), .idSelectPin1(id1),
    .sleepNPin(sleepN), .faultConditionActive(cond), .faultEvent(evt),
    .deviceStatus(devSt), .faultNPin(faultN), .driverEnable(drvEn),
    .sleepShutdown(shut));

  spi_primary_model ctrl (.serialClk(sck), .chipSelectN(csN),
    .serialDataIn(sdi), .serialDataOut(sdo), .serialDataOe(sdoOe));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  function automatic logic [15:0] rdv(input logic [7:0] a);
    logic [15:0] v;
    v = (a == SYSTEM_CONTROL_REG_ADDR) ? {15'h0, pen} : mem[a];
    if (pen)
      v[15] = ^v[14:0];
    return v;
  endfunction

  task automatic pin(input logic f, input logic e);
    cyc(12);
    chk(faultN, f);
    chk(drvEn, e);
  endtask

  task automatic do_reset(input logic m);
    reset <= 1'b1;
    md <= m;
    {id1, id0} <= 2'($urandom);
    cyc(10);
    reset <= 1'b0;
    cyc(5);
    own = {2'b00, id1, id0};
    rp = 8'h00;
    wp = 8'h00;
    pen = 1'b0;
    stsOk = 0;
  endtask

  // register write as the model sees it; status is read only
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    if (a == SYSTEM_CONTROL_REG_ADDR)
      pen = d[PARITY_EN_BIT];
    else if (a != SYS_STATUS_ADDR)
      mem[a] = d;
  endtask

  // one frame: header, n words, word bad gets wrong parity, dv fixes data
  task automatic txn(input logic rd, input logic [3:0] id,
      input logic [7:0] a, input int n, input int bad, input int dv);
    logic [63:0] tx;
    logic [15:0] h;
    logic [15:0] wq [4];
    logic ok, srv, err;
    logic pv;
    logic [7:0] pa;
    logic [15:0] pd;
    ok = !md || id == own;
    srv = ok || (!rd && id == GENERAL_CALL_ID);
    err = 1'b0;
    pv = 1'b0;
    h = md ? {rd, id, a, 3'b0} : {8'h0, rd, a[5:0], 1'b0};
    h[0] = ^h;
    tx = md ? 64'(h) : 64'(h[7:0]);
    for (int k = 0; k < n; k++)
    begin
      wq[k] = (dv < 0) ? 16'($urandom) : 16'(dv);
      wq[k][15] = ^wq[k][14:0] ^ (k == bad);
      tx = (tx << 16) | 64'(wq[k]);
    end
    ctrl.frame(n * 16 + (md ? 16 : 8), tx, rx, oe);
    if (rd && ok)
      rp = a;
    if (!rd && srv)
      wp = a;
    if (ok && stsOk > 0)
      chk(rx[16 * n +: 8], {3'h0, devSt});
    chk(oe, ok ? 16 * n + 8 : 0);
    for (int k = 0; k < n; k++)
    begin
      // word k is fetched at the edge that stores word k-1
      if (ok)
        chk(rx[16 * (n - 1 - k) +: 16], rdv(rp));
      if (pv)
        put(pa, pd);
      pv = 1'b0;
      if (!rd && srv)
      begin
        err = err | (pen & ^wq[k]);
        pv = !err;
        pa = wp;
        pd = wq[k];
        if (!err)
          wp++;
      end
      if (srv)
        rp++;
    end
    if (pv)
      put(pa, pd);
    stsOk++;
    cyc(2);
  endtask

  initial
  begin
    void'($urandom(32'hcf04));
    // a real edge so the link side clears as well
    reset <= 1'b1;
    @(posedge mclk);
    devSt <= 5'($urandom);
    for (int m = 0; m < 2; m++)
    begin
      do_reset(m[0]);
      txn(1'b0, own, 8'h01, 3, -1, -1);
      txn(1'b1, own, 8'h01, 2, -1, -1);
      txn(1'b0, own, 8'h05, 1, -1, -1);
      txn(1'b1, own, 8'h05, 1, -1, -1);
      txn(1'b0, own, 8'h06, 1, 0, -1);
      txn(1'b1, own, 8'h06, 1, -1, -1);
      pin(1'b1, 1'b1);
    end
    txn(1'b1, own ^ 4'h1, 8'h01, 1, -1, -1);
    txn(1'b0, GENERAL_CALL_ID, 8'h02, 1, -1, -1);
    txn(1'b1, GENERAL_CALL_ID, 8'h02, 1, -1, -1);
    txn(1'b1, own, 8'h02, 1, -1, -1);
    txn(1'b0, own, 8'h3f, 1, -1, 1);
    txn(1'b1, own, 8'h01, 3, -1, -1);
    stsOk = -99;
    txn(1'b0, own, 8'h01, 2, 0, -1);
    pin(1'b0, 1'b1);
    txn(1'b1, own, 8'h01, 2, -1, -1);
    txn(1'b0, own, 8'h3f, 1, -1, 3);
    pin(1'b1, 1'b1);
    // a frame cut four bits past the header
    ctrl.frame(20, 64'h0, rx, oe);
    pin(1'b0, 1'b1);
    sleepN <= 1'b0;
    cyc(5);
    sleepN <= 1'b1;
    pin(1'b1, 1'b1);
    txn(1'b1, own, 8'h3f, 1, -1, -1);
    cond <= 1'b1;
    evt <= 1'b1;
    cyc(1);
    evt <= 1'b0;
    pin(1'b0, 1'b0);
    txn(1'b0, own, 8'h3f, 1, -1, 3);
    pin(1'b0, 1'b0);
    cond <= 1'b0;
    pin(1'b0, 1'b0);
    txn(1'b0, own, 8'h3f, 1, -1, 3);
    pin(1'b1, 1'b1);
    sleepN <= 1'b0;
    cyc(40);
    chk(shut, 1'b1);
    sleepN <= 1'b1;
    cyc(10);
    chk(shut, 1'b0);
    tally_and_finish();
  end

  // generous bound over the whole sequence
  initial
  begin
    #500000;
    failures++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
